// ---- rtl/mbr_router.sv ----
// Client transaction engine with ID routing, response timeout and server port
//
// Chosen here: the strobed register port and the register offsets.
`include "mbr_consts.svh"
// How it works
// - Server port answers only its ID 1..246
// - Server port reaches local storage registers only
// - Forward wireless-range IDs over radio, default 11..60
// - Wireless first ID at 6502, default 11
// - Wireless ID count at 6503, max 100
// - One engine, transactions strictly one after another
// - No response before timeout means lost, move on
// - Timeout counts from request sent to response
// - Timeout defaults to five seconds
// - IDs 1, 199, 200, 201 are internal devices
// - Without radio, 11..60 stay wired
// - Radio retries up to eight times
// - Random wait below one slot before retry
// - Receive window 1.3 s, slot 0.04 s
module mbr_router
#(
   parameter int MS_CYCLES = `MBR_NS_PER_MS / `MBR_CLK_PERIOD_NS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Queued client operations
   input wire logic op_valid,
   input wire logic [7:0] op_id,
   output logic op_ready,
   output logic op_done,
   output logic op_lost,
   // Client bus transmitter and receiver
   output logic tx_start,
   output logic [7:0] tx_id,
   output logic [2:0] tx_dest,
   input wire logic tx_sent,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_id,
   // Radio air side
   output logic air_tx,
   output logic [7:0] air_id,
   input wire logic air_ack,
   output logic rx_window,
   // Server port
   input wire logic srv_valid,
   input wire logic [7:0] srv_id,
   input wire logic srv_local,
   input wire logic srv_write,
   input wire logic [3:0] srv_addr,
   input wire logic [15:0] srv_wdata,
   output logic srv_ack,
   output logic srv_except,
   output logic [15:0] srv_rdata
);
   mbr_pkg::mbr_state_e state;
   mbr_pkg::mbr_state_e next_state;
   mbr_pkg::mbr_dest_e dest;
   logic [7:0] srv_id_cfg;
   logic [15:0] timeout_ms;
   logic radio_present;
   logic [7:0] wl_first;
   logic [7:0] wl_count;
   logic [15:0] lost_count;
   logic last_lost;
   logic [2:0] last_dest;
   logic [7:0] cur_id;
   logic [15:0] tmo_ms;
   logic [31:0] tmo_sub;
   logic [31:0] free_sub;
   logic ms_tick;
   logic [15:0] local_mem [0:15];
   logic radio_busy;

   // Decode
   logic take_op;
   logic rsp_hit;
   logic tmo_tick;
   logic tmo_hit;
   logic [8:0] wl_end;
   logic in_wl;
   logic srv_id_ok;
   logic srv_mine;
   logic wr_srv_id;
   logic wr_timeout;
   logic wr_ctrl;
   logic wr_lost;
   logic wr_first;
   logic wr_count;
   logic [7:0] next_count;
   logic [15:0] status_word;
   logic [15:0] next_rdata;

   assign take_op = op_valid && op_ready;
   assign rsp_hit = (state == mbr_pkg::E_TIME) && rsp_valid && (rsp_id == cur_id);
   assign tmo_tick = (tmo_sub == MS_CYCLES - 1);
   assign tmo_hit = (state == mbr_pkg::E_TIME) && !rsp_hit && tmo_tick && (tmo_ms + 16'h0001 >= timeout_ms);
   assign wl_end = {1'b0, wl_first} + {1'b0, wl_count};
   // Range only active with the radio fitted; otherwise those IDs are wired
   assign in_wl = radio_present && (op_id >= wl_first) && ({1'b0, op_id} < wl_end);
   assign dest = (op_id == `MBR_ID_RADIO) ? mbr_pkg::D_RADIO :
                 (op_id == `MBR_ID_LOCAL) ? mbr_pkg::D_LOCAL :
                 (op_id == `MBR_ID_BASE) ? mbr_pkg::D_BASE :
                 (op_id == `MBR_ID_LCD) ? mbr_pkg::D_LCD :
                 in_wl ? mbr_pkg::D_WIRELESS : mbr_pkg::D_WIRED;

   assign srv_id_ok = (reg_wdata[7:0] >= `MBR_SRV_ID_MIN) && (reg_wdata[7:0] <= `MBR_SRV_ID_MAX)
                      && (reg_wdata[15:8] == 8'h00);
   assign srv_mine = srv_valid && (srv_id == srv_id_cfg);
   assign wr_srv_id = reg_wr && (reg_addr == `MBR_REG_SRV_ID);
   assign wr_timeout = reg_wr && (reg_addr == `MBR_REG_TIMEOUT);
   assign wr_ctrl = reg_wr && (reg_addr == `MBR_REG_CTRL);
   assign wr_lost = reg_wr && (reg_addr == `MBR_REG_LOST);
   assign wr_first = reg_wr && (reg_addr == `MBR_REG_WL_FIRST);
   assign wr_count = reg_wr && (reg_addr == `MBR_REG_WL_COUNT);
   // Oversized counts saturate rather than being dropped
   assign next_count = (reg_wdata > {8'h00, `MBR_WL_COUNT_MAX}) ? `MBR_WL_COUNT_MAX : reg_wdata[7:0];
   assign status_word = {7'h00, radio_busy, last_lost, last_dest, 1'b0, state};
   assign next_rdata = !reg_rd ? 16'h0000 :
                       (reg_addr == `MBR_REG_SRV_ID) ? {8'h00, srv_id_cfg} :
                       (reg_addr == `MBR_REG_TIMEOUT) ? timeout_ms :
                       (reg_addr == `MBR_REG_CTRL) ? {15'h0000, radio_present} :
                       (reg_addr == `MBR_REG_STATUS) ? status_word :
                       (reg_addr == `MBR_REG_LOST) ? lost_count :
                       (reg_addr == `MBR_REG_WL_FIRST) ? {8'h00, wl_first} :
                       (reg_addr == `MBR_REG_WL_COUNT) ? {8'h00, wl_count} : 16'h0000;

   always_comb
   begin
      next_state = state;
      case (state)
         mbr_pkg::E_IDLE: if (take_op) next_state = mbr_pkg::E_SEND;
         mbr_pkg::E_SEND: next_state = mbr_pkg::E_SENT;
         mbr_pkg::E_SENT: if (tx_sent) next_state = mbr_pkg::E_TIME;
         mbr_pkg::E_TIME: if (rsp_hit || tmo_hit) next_state = mbr_pkg::E_IDLE;
         default: next_state = mbr_pkg::E_IDLE;
      endcase
   end

   // Configuration registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         srv_id_cfg <= `MBR_SRV_ID_RST;
         timeout_ms <= `MBR_TIMEOUT_MS;
         radio_present <= 1'b1;
         wl_first <= `MBR_WL_FIRST_RST;
         wl_count <= `MBR_WL_COUNT_RST;
      end
      else
      begin
         if (wr_srv_id && srv_id_ok)
            srv_id_cfg <= reg_wdata[7:0];
         if (wr_timeout)
            timeout_ms <= reg_wdata;
         if (wr_ctrl)
            radio_present <= reg_wdata[0];
         if (wr_first)
            wl_first <= reg_wdata[7:0];
         if (wr_count)
            wl_count <= next_count;
      end
   end

   // Engine and timeout counter
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= mbr_pkg::E_IDLE;
         op_ready <= 1'b0;
         op_done <= 1'b0;
         op_lost <= 1'b0;
         tx_start <= 1'b0;
         tx_id <= 8'h00;
         tx_dest <= 3'h0;
         cur_id <= 8'h00;
         tmo_ms <= 16'h0000;
         tmo_sub <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         op_ready <= (next_state == mbr_pkg::E_IDLE) && !take_op;
         op_done <= rsp_hit;
         op_lost <= tmo_hit;
         tx_start <= (next_state == mbr_pkg::E_SEND);
         if (take_op)
         begin
            cur_id <= op_id;
            tx_id <= op_id;
            tx_dest <= dest;
         end
         // Timer runs only between request sent and response
         if (state != mbr_pkg::E_TIME)
         begin
            tmo_ms <= 16'h0000;
            tmo_sub <= 32'h0000_0000;
         end
         else if (tmo_tick)
         begin
            tmo_sub <= 32'h0000_0000;
            tmo_ms <= tmo_ms + 16'h0001;
         end
         else
            tmo_sub <= tmo_sub + 32'h0000_0001;
      end
   end

   // Status, lost counter and register read
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lost_count <= 16'h0000;
         last_lost <= 1'b0;
         last_dest <= 3'h0;
         reg_rdata <= 16'h0000;
         free_sub <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end
      else
      begin
         reg_rdata <= next_rdata;
         // A loss in the clearing cycle still counts
         if (tmo_hit)
            lost_count <= wr_lost ? 16'h0001 : lost_count + 16'h0001;
         else if (wr_lost)
            lost_count <= 16'h0000;
         if (rsp_hit || tmo_hit)
         begin
            last_lost <= tmo_hit;
            last_dest <= tx_dest;
         end
         ms_tick <= (free_sub == MS_CYCLES - 1);
         free_sub <= (free_sub == MS_CYCLES - 1) ? 32'h0000_0000 : free_sub + 32'h0000_0001;
      end
   end

   // Server port: own ID only, local storage only
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         srv_ack <= 1'b0;
         srv_except <= 1'b0;
         srv_rdata <= 16'h0000;
      end
      else
      begin
         srv_ack <= srv_mine && srv_local;
         srv_except <= srv_mine && !srv_local;
         srv_rdata <= (srv_mine && srv_local && !srv_write) ? local_mem[srv_addr] : 16'h0000;
      end
   end

   // Local storage; no reset, contents belong to the application
   always_ff @(posedge clk)
   begin
      if (srv_mine && srv_local && srv_write)
         local_mem[srv_addr] <= srv_wdata;
   end

   // Wireless requests are carried by the radio once on the bus
   mbr_radio_fwd u_radio
   (
      .clk(clk),
      .srst(srst),
      .ms_tick(ms_tick),
      .start((state == mbr_pkg::E_SENT) && tx_sent && (tx_dest == mbr_pkg::D_WIRELESS)),
      .id(cur_id),
      .air_ack(air_ack),
      .air_tx(air_tx),
      .air_id(air_id),
      .rx_window(rx_window),
      .busy(radio_busy)
   );

   a_srv_only_own: assert property (@(posedge clk) disable iff (srst)
      (srv_ack || srv_except) |-> $past(srv_valid && srv_id == srv_id_cfg))
      else $error("server port answered a foreign ID");
   a_srv_id_legal: assert property (@(posedge clk) disable iff (srst)
      (srv_id_cfg >= `MBR_SRV_ID_MIN) && (srv_id_cfg <= `MBR_SRV_ID_MAX))
      else $error("server ID outside legal range");
   a_srv_local_only: assert property (@(posedge clk) disable iff (srst)
      srv_ack |-> $past(srv_local))
      else $error("server port acked a non-local access");
   a_wl_route: assert property (@(posedge clk) disable iff (srst)
      (take_op && op_id >= wl_first && {1'b0, op_id} < wl_end && op_id > `MBR_ID_RADIO
       && op_id < `MBR_ID_LOCAL) |=> (tx_dest == (radio_present ? 3'h2 : 3'h0)))
      else $error("wireless range routed wrongly");
   a_count_cap: assert property (@(posedge clk) disable iff (srst) wl_count <= `MBR_WL_COUNT_MAX)
      else $error("wireless count above limit");
   a_one_at_time: assert property (@(posedge clk) disable iff (srst)
      take_op |=> !op_ready && tx_start ##1 !tx_start)
      else $error("second operation taken while busy");
   a_lost_after_tmo: assert property (@(posedge clk) disable iff (srst)
      op_lost |-> $past(state == mbr_pkg::E_TIME) && $past(tmo_ms) + 16'h0001 >= $past(timeout_ms))
      else $error("lost declared before timeout");
   a_timer_start: assert property (@(posedge clk) disable iff (srst)
      (state == mbr_pkg::E_SENT && tx_sent) |=> (state == mbr_pkg::E_TIME && tmo_ms == 16'h0000))
      else $error("timer not started at request sent");
   a_tmo_default: assert property (@(posedge clk) disable iff (srst)
      $past(srst) |-> timeout_ms == `MBR_TIMEOUT_MS)
      else $error("timeout default wrong after reset");
   a_fixed_ids: assert property (@(posedge clk) disable iff (srst)
      (take_op && op_id == `MBR_ID_LOCAL) |=> tx_dest == 3'h3)
      else $error("local register ID misrouted");
   a_resp_cancel: assert property (@(posedge clk) disable iff (srst)
      rsp_hit |=> op_done && !op_lost && state == mbr_pkg::E_IDLE ##1 op_ready)
      else $error("response did not end transaction");

   c_done: cover property (@(posedge clk) disable iff (srst) op_done);
   c_lost: cover property (@(posedge clk) disable iff (srst) op_lost);
   c_wireless: cover property (@(posedge clk) disable iff (srst) tx_start && tx_dest == 3'h2);
   c_srv: cover property (@(posedge clk) disable iff (srst) srv_ack ##1 srv_except);
endmodule // mbr_router

// ---- shared/mbr_consts.svh ----
// Offsets, reset values, identifiers and timing constants of the router
`ifndef MBR_CONSTS_SVH
`define MBR_CONSTS_SVH

// Timing
`define MBR_CLK_PERIOD_NS 4
`define MBR_NS_PER_MS 1000000
`define MBR_TIMEOUT_MS 16'h1388
`define MBR_SLOT_MS 16'h0028
`define MBR_WIN_MS 16'h0514
`define MBR_RETRIES 4'h8

// Station identifiers
`define MBR_SRV_ID_MIN 8'h01
`define MBR_SRV_ID_MAX 8'hF6
`define MBR_SRV_ID_RST 8'h01
`define MBR_ID_RADIO 8'h01
`define MBR_ID_LOCAL 8'hC7
`define MBR_ID_BASE 8'hC8
`define MBR_ID_LCD 8'hC9
`define MBR_WL_FIRST_RST 8'h0B
`define MBR_WL_COUNT_RST 8'h32
`define MBR_WL_COUNT_MAX 8'h64

// Register offsets
`define MBR_REG_SRV_ID 16'h0000
`define MBR_REG_TIMEOUT 16'h0001
`define MBR_REG_CTRL 16'h0002
`define MBR_REG_STATUS 16'h0003
`define MBR_REG_LOST 16'h0004
`define MBR_REG_WL_FIRST 16'h1966
`define MBR_REG_WL_COUNT 16'h1967

`endif

// ---- shared/mbr_pkg.sv ----
// Types shared by the router engine and the radio forwarder
package mbr_pkg;
   typedef enum logic [2:0] {
      E_IDLE = 3'b000,
      E_SEND = 3'b001,
      E_SENT = 3'b010,
      E_TIME = 3'b011
   } mbr_state_e;

   typedef enum logic [2:0] {
      D_WIRED = 3'b000,
      D_RADIO = 3'b001,
      D_WIRELESS = 3'b010,
      D_LOCAL = 3'b011,
      D_BASE = 3'b100,
      D_LCD = 3'b101
   } mbr_dest_e;

   typedef enum logic [1:0] {
      R_IDLE = 2'b00,
      R_TX = 2'b01,
      R_WAIT = 2'b10,
      R_BACK = 2'b11
   } mbr_radio_e;
endpackage

// ---- rtl/mbr_radio_fwd.sv ----
// Radio forwarder: slot-paced attempts, bounded retries, random backoff
`include "mbr_consts.svh"
module mbr_radio_fwd
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Millisecond tick
   input wire logic ms_tick,
   // Forward request
   input wire logic start,
   input wire logic [7:0] id,
   // Air side
   input wire logic air_ack,
   output logic air_tx,
   output logic [7:0] air_id,
   output logic rx_window,
   output logic busy
);
   mbr_pkg::mbr_radio_e state;
   mbr_pkg::mbr_radio_e next_state;
   logic [3:0] retries;
   logic [15:0] ms_cnt;
   logic [15:0] win_cnt;
   logic [15:0] lfsr;
   logic [5:0] rnd;
   logic slot_over;
   logic give_up;

   // Backoff of 0..39 ms, never a full slot
   assign rnd = (lfsr[5:0] > 6'h27) ? (lfsr[5:0] - 6'h18) : lfsr[5:0];
   assign slot_over = ms_tick && (ms_cnt == `MBR_SLOT_MS - 16'h0001);
   assign give_up = (retries == `MBR_RETRIES);

   always_comb
   begin
      next_state = state;
      case (state)
         mbr_pkg::R_IDLE: if (start) next_state = mbr_pkg::R_TX;
         mbr_pkg::R_TX: next_state = mbr_pkg::R_WAIT;
         mbr_pkg::R_WAIT:
            if (air_ack) next_state = mbr_pkg::R_IDLE;
            else if (slot_over) next_state = give_up ? mbr_pkg::R_IDLE : mbr_pkg::R_BACK;
         mbr_pkg::R_BACK: if (ms_cnt == 16'h0000) next_state = mbr_pkg::R_TX;
         default: next_state = mbr_pkg::R_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= mbr_pkg::R_IDLE;
         retries <= 4'h0;
         ms_cnt <= 16'h0000;
         lfsr <= 16'hACE1;
         air_tx <= 1'b0;
         air_id <= 8'h00;
         busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         air_tx <= (next_state == mbr_pkg::R_TX);
         busy <= (next_state != mbr_pkg::R_IDLE);
         if (state == mbr_pkg::R_IDLE && start)
         begin
            retries <= 4'h0;
            air_id <= id;
         end
         if (state == mbr_pkg::R_TX)
            ms_cnt <= 16'h0000;
         else if (state == mbr_pkg::R_WAIT && slot_over && !give_up)
         begin
            retries <= retries + 4'h1;
            ms_cnt <= {10'h000, rnd};
         end
         else if (state == mbr_pkg::R_WAIT && ms_tick)
            ms_cnt <= ms_cnt + 16'h0001;
         else if (state == mbr_pkg::R_BACK && ms_tick && ms_cnt != 16'h0000)
            ms_cnt <= ms_cnt - 16'h0001;
      end
   end

   // Receive window opens once per window period
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         win_cnt <= 16'h0000;
         rx_window <= 1'b0;
      end
      else
      begin
         rx_window <= ms_tick && (win_cnt == `MBR_WIN_MS - 16'h0001);
         if (ms_tick)
            win_cnt <= (win_cnt == `MBR_WIN_MS - 16'h0001) ? 16'h0000 : win_cnt + 16'h0001;
      end
   end

   a_retry_bound: assert property (@(posedge clk) disable iff (srst) retries <= `MBR_RETRIES)
      else $error("retry count above limit");
   a_backoff_short: assert property (@(posedge clk) disable iff (srst)
      (state == mbr_pkg::R_BACK) |-> (ms_cnt < `MBR_SLOT_MS))
      else $error("backoff longer than one slot");
   a_window_period: assert property (@(posedge clk) disable iff (srst)
      rx_window |-> (win_cnt == 16'h0000))
      else $error("receive window off its period");
endmodule // mbr_radio_fwd

// ---- tb/mbr_srv_model.sv ----
// Far side of the client bus: wired servers and the remote radio
module mbr_srv_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Client bus
   input wire logic tx_start,
   input wire logic [7:0] tx_id,
   output logic tx_sent,
   output logic rsp_valid,
   output logic [7:0] rsp_id,
   // Air side
   input wire logic air_tx,
   output logic air_ack,
   // Behaviour chosen by the bench
   input wire logic [7:0] absent_id,
   input wire logic [15:0] rsp_delay,
   input wire logic ack_en
);
   timeunit 1ns;
   timeprecision 100ps;
   int sent_cnt = 0;
   int rsp_cnt = 0;
   int ack_cnt = 0;
   logic [7:0] req_id = 8'h00;
   initial
   begin
      tx_sent = 1'b0;
      rsp_valid = 1'b0;
      rsp_id = 8'h00;
      air_ack = 1'b0;
   end
   always @(posedge clk)
   begin
      tx_sent <= (sent_cnt == 1);
      rsp_valid <= (rsp_cnt == 1);
      air_ack <= (ack_cnt == 1);
      // Idle response ID toggles between the last ID and its inverse while rsp_valid stays low
      rsp_id <= (rsp_cnt == 1) ? req_id : ~rsp_id;
      sent_cnt <= (sent_cnt > 0) ? sent_cnt - 1 : 0;
      rsp_cnt <= (rsp_cnt > 0) ? rsp_cnt - 1 : 0;
      ack_cnt <= (ack_cnt > 0) ? ack_cnt - 1 : 0;
      if (srst)
         sent_cnt <= 0;
      else if (tx_start)
      begin
         sent_cnt <= 4;
         req_id <= tx_id;
      end
      // Only present servers answer; wired ones sit at 2..10 or 61..198
      if (sent_cnt == 1 && req_id != absent_id)
         rsp_cnt <= rsp_delay;
      if (air_tx && ack_en)
         ack_cnt <= 6;
   end
endmodule // mbr_srv_model

// ---- tb/mbr_router_tb_top.sv ----
// Self-checking bench for the router: registers, routing, timeout, server port, radio
`include "mbr_consts.svh"
module mbr_router_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MS = 10;
   // Short timeout, as a star gateway setup would allow
   localparam logic [15:0] TMO = 16'h0003;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic op_valid = 1'b0;
   logic [7:0] op_id = 8'h00;
   logic srv_valid = 1'b0;
   logic [7:0] srv_id = 8'h00;
   logic srv_local = 1'b0;
   logic srv_write = 1'b0;
   logic [3:0] srv_addr = 4'h0;
   logic [15:0] srv_wdata = 16'h0000;
   logic [7:0] absent_id = 8'hFF;
   logic [15:0] rsp_delay = 16'h000A;
   logic ack_en = 1'b1;
   logic [15:0] reg_rdata, srv_rdata;
   logic op_ready, op_done, op_lost, tx_start, tx_sent, rsp_valid, air_tx, air_ack, rx_window, srv_ack, srv_except;
   logic [7:0] tx_id, rsp_id, air_id, air_seen;
   logic [2:0] tx_dest;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int sent_cyc = 0;
   int air_cnt = 0;
   int air_last = 0;
   int gap_min = 99999;
   int gap_max = 0;
   int win_n = 0;
   int win_prev = 0;
   int win_last = 0;
   always #2 clk = ~clk;
   mbr_router #(.MS_CYCLES(MS)) mbr_router_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_id(op_id),
      .op_ready(op_ready), .op_done(op_done), .op_lost(op_lost), .tx_start(tx_start), .tx_id(tx_id),
      .tx_dest(tx_dest), .tx_sent(tx_sent), .rsp_valid(rsp_valid), .rsp_id(rsp_id), .air_tx(air_tx),
      .air_id(air_id), .air_ack(air_ack), .rx_window(rx_window), .srv_valid(srv_valid), .srv_id(srv_id),
      .srv_local(srv_local), .srv_write(srv_write), .srv_addr(srv_addr), .srv_wdata(srv_wdata),
      .srv_ack(srv_ack), .srv_except(srv_except), .srv_rdata(srv_rdata));
   mbr_srv_model mbr_srv_model_i (.clk(clk), .srst(srst), .tx_start(tx_start), .tx_id(tx_id), .tx_sent(tx_sent),
      .rsp_valid(rsp_valid), .rsp_id(rsp_id), .air_tx(air_tx), .air_ack(air_ack), .absent_id(absent_id),
      .rsp_delay(rsp_delay), .ack_en(ack_en));
   always @(posedge clk)
   begin
      cyc++;
      if (tx_sent === 1'b1)
         sent_cyc = cyc;
      if (rx_window === 1'b1)
      begin
         win_prev = win_last;
         win_last = cyc;
         win_n++;
      end
      if (air_tx === 1'b1)
      begin
         if (air_cnt > 0 && cyc - air_last < gap_min)
            gap_min = cyc - air_last;
         if (air_cnt > 0 && cyc - air_last > gap_max)
            gap_max = cyc - air_last;
         air_last = cyc;
         air_seen = air_id;
         air_cnt++;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_expect(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, e);
   endtask
   task automatic run_op(input logic [7:0] id, input logic [2:0] dest, input logic lost, output int span);
      int n;
      n = 0;
      while (op_ready !== 1'b1 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      op_valid <= 1'b1;
      op_id <= id;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      check({op_ready, tx_start}, 2'b01);
      n = 0;
      while (op_done !== 1'b1 && op_lost !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      span = cyc - sent_cyc;
      check(op_done, !lost);
      check(op_lost, lost);
      check(tx_id, id);
      check(tx_dest, dest);
   endtask
   task automatic t_reset;
      reg_expect(`MBR_REG_SRV_ID, 16'h0001);
      reg_expect(`MBR_REG_TIMEOUT, `MBR_TIMEOUT_MS);
      reg_expect(`MBR_REG_CTRL, 16'h0001);
      reg_expect(`MBR_REG_WL_FIRST, 16'h000B);
      reg_expect(`MBR_REG_WL_COUNT, 16'h0032);
      reg_expect(16'h0010, 16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_regs;
      reg_write(`MBR_REG_WL_COUNT, 16'h00FF);
      reg_expect(`MBR_REG_WL_COUNT, 16'h0064);
      reg_write(`MBR_REG_WL_COUNT, 16'h0032);
      reg_write(`MBR_REG_SRV_ID, 16'h0000);
      reg_expect(`MBR_REG_SRV_ID, 16'h0001);
      reg_write(`MBR_REG_SRV_ID, 16'h00F7);
      reg_expect(`MBR_REG_SRV_ID, 16'h0001);
      reg_write(`MBR_REG_SRV_ID, 16'h00F6);
      reg_expect(`MBR_REG_SRV_ID, 16'h00F6);
      reg_write(16'h0010, 16'hFFFF);
      reg_expect(16'h0010, 16'h0000);
      reg_write(`MBR_REG_TIMEOUT, TMO);
      reg_expect(`MBR_REG_TIMEOUT, TMO);
      $display("t_regs done");
   endtask
   task automatic t_route;
      logic [7:0] ids [8] = '{8'h01, 8'hC7, 8'hC8, 8'hC9, 8'h05, 8'h0B, 8'h3C, 8'h3D};
      logic [2:0] dst [8] = '{mbr_pkg::D_RADIO, mbr_pkg::D_LOCAL, mbr_pkg::D_BASE, mbr_pkg::D_LCD,
         mbr_pkg::D_WIRED, mbr_pkg::D_WIRELESS, mbr_pkg::D_WIRELESS, mbr_pkg::D_WIRED};
      int span;
      for (int i = 0; i < 8; i++)
         run_op(ids[i], dst[i], 1'b0, span);
      reg_write(`MBR_REG_CTRL, 16'h0000);
      run_op(8'h0B, mbr_pkg::D_WIRED, 1'b0, span);
      reg_write(`MBR_REG_CTRL, 16'h0001);
      reg_write(`MBR_REG_WL_FIRST, 16'h003D);
      reg_write(`MBR_REG_WL_COUNT, 16'h0002);
      run_op(8'h3E, mbr_pkg::D_WIRELESS, 1'b0, span);
      run_op(8'h3F, mbr_pkg::D_WIRED, 1'b0, span);
      run_op(8'h0B, mbr_pkg::D_WIRED, 1'b0, span);
      reg_write(`MBR_REG_WL_FIRST, 16'h000B);
      reg_write(`MBR_REG_WL_COUNT, 16'h0032);
      $display("t_route done");
   endtask
   task automatic t_lost;
      int span;
      int late;
      absent_id <= 8'h07;
      run_op(8'h07, mbr_pkg::D_WIRED, 1'b1, span);
      check(span >= TMO * MS && span <= TMO * MS + 3, 1'b1);
      reg_expect(`MBR_REG_LOST, 16'h0001);
      run_op(8'h05, mbr_pkg::D_WIRED, 1'b0, span);
      reg_write(`MBR_REG_LOST, 16'h0000);
      reg_expect(`MBR_REG_LOST, 16'h0000);
      // A response after the deadline must not complete anything
      rsp_delay <= 16'h0028;
      run_op(8'h05, mbr_pkg::D_WIRED, 1'b1, span);
      late = 0;
      repeat (30)
      begin
         @(posedge clk);
         #1;
         late += (op_done === 1'b1);
      end
      check(late, 0);
      reg_expect(`MBR_REG_STATUS, 16'h0080);
      rsp_delay <= 16'h000A;
      $display("t_lost done");
   endtask
   task automatic srv_req(input logic [7:0] id, input logic loc, input logic wr, input logic [15:0] d);
      @(posedge clk);
      srv_valid <= 1'b1;
      srv_id <= id;
      srv_local <= loc;
      srv_write <= wr;
      srv_addr <= 4'h3;
      srv_wdata <= d;
      @(posedge clk);
      srv_valid <= 1'b0;
      #1;
   endtask
   task automatic t_server;
      reg_write(`MBR_REG_SRV_ID, 16'h002A);
      srv_req(8'h2A, 1'b1, 1'b1, 16'hBEEF);
      check(srv_ack, 1'b1);
      srv_req(8'h2A, 1'b1, 1'b0, 16'h0000);
      check(srv_rdata, 16'hBEEF);
      srv_req(8'h2B, 1'b1, 1'b0, 16'h0000);
      check({srv_ack, srv_except}, 2'b00);
      srv_req(8'h2A, 1'b0, 1'b0, 16'h0000);
      check({srv_ack, srv_except}, 2'b01);
      $display("t_server done");
   endtask
   task automatic t_radio;
      int span;
      int k;
      ack_en <= 1'b0;
      air_cnt = 0;
      gap_min = 99999;
      gap_max = 0;
      run_op(8'h14, mbr_pkg::D_WIRELESS, 1'b0, span);
      repeat (9000) @(posedge clk);
      check(air_cnt, 9);
      check(air_seen, 8'h14);
      // Slot wait counts whole ms ticks, so a gap may fall short by up to one tick
      check(gap_min >= 39 * MS, 1'b1);
      check(gap_max <= 80 * MS, 1'b1);
      ack_en <= 1'b1;
      air_cnt = 0;
      run_op(8'h14, mbr_pkg::D_WIRELESS, 1'b0, span);
      repeat (1000) @(posedge clk);
      check(air_cnt, 1);
      k = 0;
      while (win_n < 2 && k < 30000)
      begin
         @(posedge clk);
         k++;
      end
      check(win_last - win_prev, 1300 * MS);
      $display("t_radio done");
   endtask
   initial
   begin
      #400000;
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_regs;
      t_route;
      t_lost;
      t_server;
      t_radio;
      wrap_up;
   end
endmodule // mbr_router_tb_top
